// File: core/cis_pkg.sv
// Constants, level codes and state types of the idle-state sequencer.
// Assumes a single system clock; no bus reaches these values.
package cis_pkg;

	localparam int NUM_CORES   = 2;
	localparam int NUM_THREADS = 2;
	localparam int LVL_W       = 4;
	localparam int LLC_WAYS    = 8;
	localparam int WAY_W       = 3;
	localparam int CNT_W       = 4;

	// Idle level codes, ordered so a smaller code is a shallower level
	localparam logic [LVL_W-1:0] LVL_C0  = 4'h0;
	localparam logic [LVL_W-1:0] LVL_C1  = 4'h1;
	localparam logic [LVL_W-1:0] LVL_C1E = 4'h2;
	localparam logic [LVL_W-1:0] LVL_C3  = 4'h3;
	localparam logic [LVL_W-1:0] LVL_C6  = 4'h4;
	localparam logic [LVL_W-1:0] LVL_C7  = 4'h5;
	localparam logic [LVL_W-1:0] LVL_C8  = 4'h6;
	localparam logic [LVL_W-1:0] LVL_C9  = 4'h7;
	localparam logic [LVL_W-1:0] LVL_C10 = 4'h8;

	// Sleep requests
	localparam logic [1:0] SLP_S0 = 2'h0;
	localparam logic [1:0] SLP_S3 = 2'h1;
	localparam logic [1:0] SLP_S4 = 2'h2;
	localparam logic [1:0] SLP_S5 = 2'h3;

	localparam logic [WAY_W-1:0] WAY_LAST = 3'h7;
	localparam logic [WAY_W-1:0] WAY_ONE  = 3'h1;

	// Core rail settle time before restore may start
	localparam int CLK_PERIOD_NS = 100;
	localparam int CORE_PWR_NS   = 1000;
	localparam logic [CNT_W-1:0] CORE_PWR_CYC =
		CNT_W'((CORE_PWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

	typedef enum logic [2:0] {
		C_ACTIVE, C_HALT, C_FLUSH, C_GATED, C_SAVE, C_OFF, C_PWRUP, C_RESTORE
	} cis_core_st_t;

	typedef enum logic [3:0] {
		P_RUN, P_LLC_FLUSH, P_LLC_OFF, P_SAVE, P_DOM_OFF, P_VCC_ZERO, P_VR_LP,
		P_DEEP, P_VR_UP, P_VCC_UP, P_PLL_ON, P_RESTORE, P_LLC_ON
	} cis_pkg_st_t;

endpackage : cis_pkg

// File: core/cis_core_seq.sv
// One core's idle sequencer: halt, cache flush, clock gate, save, power off.
// Assumes save, flush and restore engines answer with done pulses.
`timescale 1ns/1ps
module cis_core_seq (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic [cis_pkg::LVL_W-1:0]   level,
	input  wire logic                        wake,
	input  wire logic                        pkg_ready,
	input  wire logic                        flush_done,
	input  wire logic                        save_done,
	input  wire logic                        restore_done,
	output logic                             flush_req,
	output logic                             save_req,
	output logic                             restore_req,
	output logic                             clk_en,
	output logic                             pwr_en,
	output logic                             low_freq,
	output logic                             in_active,
	output logic                             in_halt,
	output logic                             in_off,
	output logic                             wake_pend
);

	typedef struct packed {
		cis_pkg::cis_core_st_t       st;
		logic                        pend;
		logic [cis_pkg::CNT_W-1:0]   cnt;
		logic                        clk_en;
		logic                        pwr_en;
		logic                        low_freq;
	} cis_core_state_t;

	cis_core_state_t q, d;
	logic            pend_n;

	////////////////////////////////////////////////////////////////////////
	// Next state; wake sets pending, which clears in active even when wake is high
	always_comb
	begin
		d      = q;
		pend_n = q.pend | wake;
		d.pend = pend_n;
		unique case (q.st)
			cis_pkg::C_ACTIVE:
			begin
				d.pend     = 1'b0;
				d.clk_en   = 1'b1;
				d.pwr_en   = 1'b1;
				d.low_freq = 1'b0;
				if (level != cis_pkg::LVL_C0 && !wake)
				begin
					if (level >= cis_pkg::LVL_C3)
						d.st = cis_pkg::C_FLUSH;
					else
					begin
						d.st       = cis_pkg::C_HALT;
						d.low_freq = (level == cis_pkg::LVL_C1E);
					end
				end
			end
			cis_pkg::C_HALT:
			begin
				if (pend_n)
					d.st = cis_pkg::C_ACTIVE;
			end
			cis_pkg::C_FLUSH:
			begin
				if (flush_done)
				begin
					d.clk_en = 1'b0;
					d.st     = cis_pkg::C_GATED;
				end
			end
			cis_pkg::C_GATED:
			begin
				if (level >= cis_pkg::LVL_C6 && !pend_n)
					d.st = cis_pkg::C_SAVE;
				else if (pend_n && pkg_ready)
				begin
					d.clk_en = 1'b1;
					d.st     = cis_pkg::C_ACTIVE;
				end
			end
			cis_pkg::C_SAVE:
			begin
				if (save_done)
				begin
					d.pwr_en = 1'b0;
					d.st     = cis_pkg::C_OFF;
				end
			end
			cis_pkg::C_OFF:
			begin
				if (pend_n && pkg_ready)
				begin
					d.pwr_en = 1'b1;
					d.cnt    = cis_pkg::CORE_PWR_CYC - cis_pkg::CNT_ONE;
					d.st     = cis_pkg::C_PWRUP;
				end
			end
			cis_pkg::C_PWRUP:
			begin
				if (q.cnt == '0)
					d.st = cis_pkg::C_RESTORE;
				else
					d.cnt = q.cnt - cis_pkg::CNT_ONE;
			end
			cis_pkg::C_RESTORE:
			begin
				if (restore_done)
				begin
					d.clk_en = 1'b1;
					d.st     = cis_pkg::C_ACTIVE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			q <= '{cis_pkg::C_ACTIVE, 1'b0, '0, 1'b1, 1'b1, 1'b0};
		else
			q <= d;
	end

	// Requests are held for as long as the step lasts
	assign flush_req   = (q.st == cis_pkg::C_FLUSH);
	assign save_req    = (q.st == cis_pkg::C_SAVE);
	assign restore_req = (q.st == cis_pkg::C_RESTORE);
	assign clk_en      = q.clk_en;
	assign pwr_en      = q.pwr_en;
	assign low_freq    = q.low_freq;
	assign in_active   = (q.st == cis_pkg::C_ACTIVE);
	assign in_halt     = (q.st == cis_pkg::C_HALT);
	assign in_off      = (q.st == cis_pkg::C_OFF);
	assign wake_pend   = q.pend;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_active_runs: assert property (@(posedge sys_clk) disable iff (rst)
		q.st == cis_pkg::C_ACTIVE |-> q.clk_en && q.pwr_en)
		else $error("active core without clock or voltage");
	a_c1e_low_point: assert property (@(posedge sys_clk) disable iff (rst)
		($past(q.st) == cis_pkg::C_ACTIVE && q.st == cis_pkg::C_HALT) |->
		(q.low_freq == ($past(level) == cis_pkg::LVL_C1E)))
		else $error("halt operating point wrong");
	a_gate_after_flush: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(q.clk_en) |-> $past(q.st) == cis_pkg::C_FLUSH && $past(flush_done))
		else $error("clock gated before flush done");
	a_save_before_off: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(q.pwr_en) |-> $past(q.st) == cis_pkg::C_SAVE && $past(save_done))
		else $error("core voltage removed before save");
	a_halt_wakes: assert property (@(posedge sys_clk) disable iff (rst)
		(q.st == cis_pkg::C_HALT && wake) |=> q.st == cis_pkg::C_ACTIVE)
		else $error("halted core missed wake");
	a_entry_via_active: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(q.st == cis_pkg::C_HALT || q.st == cis_pkg::C_FLUSH) |->
		$past(q.st) == cis_pkg::C_ACTIVE)
		else $error("idle entry not from active");
	a_restore_powered: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(q.st == cis_pkg::C_RESTORE) |->
		q.pwr_en && !q.clk_en && $past(q.st) == cis_pkg::C_PWRUP)
		else $error("restore before voltage settled");

endmodule : cis_core_seq

// File: core/cis_top.sv
// Top of the idle-state sequencer: core resolution, package deep levels,
// regulator requests, sleep states and interrupt steering.
// Assumes regulator acks come from pins; all other inputs are on sys_clk.
`timescale 1ns/1ps
module cis_top (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [cis_pkg::NUM_CORES*cis_pkg::NUM_THREADS
	                   *cis_pkg::LVL_W-1:0] thread_lvl,
	input  wire logic [cis_pkg::NUM_CORES-1:0] wake_monitor,
	input  wire logic [cis_pkg::NUM_CORES-1:0] wake_timer,
	input  wire logic                   irq_in,
	input  wire logic                   steer_perf,
	input  wire logic [cis_pkg::NUM_CORES-1:0] core_busy,
	input  wire logic [cis_pkg::NUM_CORES-1:0] core_flush_done,
	input  wire logic [cis_pkg::NUM_CORES-1:0] core_save_done,
	input  wire logic [cis_pkg::NUM_CORES-1:0] core_restore_done,
	input  wire logic                   llc_way_done,
	input  wire logic                   pkg_save_done,
	input  wire logic                   pkg_restore_done,
	input  wire logic                   pll_lock,
	input  wire logic                   vr_zero_ack,
	input  wire logic                   vr_lp_ack,
	input  wire logic [1:0]             sleep_req,
	output logic [cis_pkg::NUM_CORES-1:0] core_flush_req,
	output logic [cis_pkg::NUM_CORES-1:0] core_save_req,
	output logic [cis_pkg::NUM_CORES-1:0] core_restore_req,
	output logic [cis_pkg::NUM_CORES-1:0] core_clk_en,
	output logic [cis_pkg::NUM_CORES-1:0] core_pwr_en,
	output logic [cis_pkg::NUM_CORES-1:0] core_low_freq,
	output logic [cis_pkg::NUM_CORES-1:0] core_running,
	output logic [cis_pkg::NUM_CORES-1:0] irq_deliver,
	output logic                        llc_flush_req,
	output logic [cis_pkg::WAY_W-1:0]   llc_way_idx,
	output logic                        llc_pwr_en,
	output logic                        sa_pwr_en,
	output logic                        pkg_save_req,
	output logic                        pkg_restore_req,
	output logic                        dom_pwr_en,
	output logic                        pll_pwr_en,
	output logic                        vcc_zero_req,
	output logic                        vr_lowpwr_req,
	output logic                        mem_retain,
	output logic                        platform_off_req
);

	localparam int NC = cis_pkg::NUM_CORES;
	localparam int LW = cis_pkg::LVL_W;
	localparam logic [NC-1:0] CORE_FIRST = 2'h1;

	typedef struct packed {
		cis_pkg::cis_pkg_st_t        st;
		logic [cis_pkg::WAY_W-1:0]   way;
		logic                        llc_on;
		logic                        sa_on;
		logic                        dom_on;
		logic                        pll_on;
		logic                        saved;
		logic                        zero_req;
		logic                        lp_req;
		logic                        mem_ret;
		logic                        plat_off;
		logic [NC-1:0]               irq;
		logic [1:0][2:0]             sync;
		logic [1:0]                  vr_f;
	} cis_top_state_t;

	cis_top_state_t q, d;

	logic [NC-1:0][LW-1:0] core_lvl;
	logic [NC-1:0]         c_act, c_halt, c_off, c_pend;
	logic [LW-1:0]         pkg_min;
	logic                  all_c7, wake_any, deeper;
	logic [NC-1:0]         cand;
	logic [1:0]            vr_pin;

	////////////////////////////////////////////////////////////////////////
	// Per core: thread resolution and core sequencer
	for (genvar c = 0; c < NC; c++)
	begin : g_core
		logic [LW-1:0] t0, t1;
		assign t0 = thread_lvl[(c*2)*LW +: LW];
		assign t1 = thread_lvl[(c*2+1)*LW +: LW];
		assign core_lvl[c] = (t0 < t1) ? t0 : t1;

		cis_core_seq u_seq (
			.sys_clk      (sys_clk),
			.rst          (rst),
			.level        (core_lvl[c]),
			.wake         (wake_monitor[c] | wake_timer[c] | q.irq[c]),
			.pkg_ready    (q.st == cis_pkg::P_RUN),
			.flush_done   (core_flush_done[c]),
			.save_done    (core_save_done[c]),
			.restore_done (core_restore_done[c]),
			.flush_req    (core_flush_req[c]),
			.save_req     (core_save_req[c]),
			.restore_req  (core_restore_req[c]),
			.clk_en       (core_clk_en[c]),
			.pwr_en       (core_pwr_en[c]),
			.low_freq     (core_low_freq[c]),
			.in_active    (c_act[c]),
			.in_halt      (c_halt[c]),
			.in_off       (c_off[c]),
			.wake_pend    (c_pend[c])
		);
	end

	// Package depth is the shallowest core; two cores only
	assign pkg_min  = (core_lvl[0] < core_lvl[1]) ? core_lvl[0] : core_lvl[1];
	assign all_c7   = (&c_off) && (pkg_min >= cis_pkg::LVL_C7);
	assign wake_any = (|c_pend) | (|wake_monitor) | (|wake_timer) | (|q.irq);
	assign vr_pin   = {vr_lp_ack, vr_zero_ack};

	////////////////////////////////////////////////////////////////////////
	// Steering candidates; deep cores are the last resort
	always_comb
	begin
		if (steer_perf)
			cand = (|c_halt) ? c_halt
			     : (|(c_act & ~core_busy)) ? (c_act & ~core_busy)
			     : (|c_act) ? c_act : CORE_FIRST;
		else
			cand = (|c_act) ? c_act : (|c_halt) ? c_halt : CORE_FIRST;
	end

	////////////////////////////////////////////////////////////////////////
	// Package sequencer next state
	always_comb
	begin
		d     = q;
		d.irq = irq_in ? (cand & (~cand + CORE_FIRST)) : '0;
		// Regulator acks: three stages, taken when last two agree
		for (int i = 0; i < 2; i++)
		begin
			d.sync[i] = {q.sync[i][1:0], vr_pin[i]};
			if (q.sync[i][1] == q.sync[i][2])
				d.vr_f[i] = q.sync[i][2];
		end
		deeper = 1'b0;
		unique case (q.st)
			cis_pkg::P_RUN:
			begin
				if (all_c7 && !wake_any)
				begin
					d.way = '0;
					d.st  = cis_pkg::P_LLC_FLUSH;
				end
			end
			cis_pkg::P_LLC_FLUSH:
			begin
				if (wake_any)
					d.st = cis_pkg::P_LLC_ON;
				else if (llc_way_done)
				begin
					if (q.way == cis_pkg::WAY_LAST)
						d.st = cis_pkg::P_LLC_OFF;
					else
						d.way = q.way + cis_pkg::WAY_ONE;
				end
			end
			cis_pkg::P_LLC_OFF:
			begin
				d.llc_on = 1'b0;
				d.sa_on  = 1'b0;
				deeper   = (pkg_min >= cis_pkg::LVL_C8) && !wake_any;
				d.st     = deeper ? cis_pkg::P_SAVE : cis_pkg::P_DEEP;
			end
			cis_pkg::P_SAVE:
			begin
				if (pkg_save_done)
				begin
					d.saved = 1'b1;
					d.st    = cis_pkg::P_DOM_OFF;
				end
			end
			cis_pkg::P_DOM_OFF:
			begin
				d.dom_on = 1'b0;
				d.pll_on = 1'b0;
				deeper   = (pkg_min >= cis_pkg::LVL_C9) && !wake_any;
				d.st     = deeper ? cis_pkg::P_VCC_ZERO : cis_pkg::P_DEEP;
			end
			cis_pkg::P_VCC_ZERO:
			begin
				d.zero_req = 1'b1;
				deeper     = (pkg_min >= cis_pkg::LVL_C10) && !wake_any;
				if (q.vr_f[0])
					d.st = deeper ? cis_pkg::P_VR_LP : cis_pkg::P_DEEP;
			end
			cis_pkg::P_VR_LP:
			begin
				d.lp_req = 1'b1;
				if (q.vr_f[1])
					d.st = cis_pkg::P_DEEP;
			end
			cis_pkg::P_DEEP:
			begin
				if (sleep_req == cis_pkg::SLP_S3)
					d.mem_ret = 1'b1;
				if (sleep_req == cis_pkg::SLP_S4 || sleep_req == cis_pkg::SLP_S5)
					d.plat_off = 1'b1;
				if (wake_any)
				begin
					d.mem_ret  = 1'b0;
					d.plat_off = 1'b0;
					d.st       = cis_pkg::P_VR_UP;
				end
			end
			cis_pkg::P_VR_UP:
			begin
				d.lp_req = 1'b0;
				if (!q.vr_f[1])
					d.st = cis_pkg::P_VCC_UP;
			end
			cis_pkg::P_VCC_UP:
			begin
				d.zero_req = 1'b0;
				if (!q.vr_f[0])
					d.st = cis_pkg::P_PLL_ON;
			end
			cis_pkg::P_PLL_ON:
			begin
				d.dom_on = 1'b1;
				d.pll_on = 1'b1;
				if (pll_lock)
					d.st = cis_pkg::P_RESTORE;
			end
			cis_pkg::P_RESTORE:
			begin
				if (!q.saved || pkg_restore_done)
				begin
					d.saved = 1'b0;
					d.st    = cis_pkg::P_LLC_ON;
				end
			end
			cis_pkg::P_LLC_ON:
			begin
				d.llc_on = 1'b1;
				d.sa_on  = 1'b1;
				d.st     = cis_pkg::P_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			q <= '{cis_pkg::P_RUN, '0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
			       1'b0, 1'b0, 1'b0, '0, '0, '0};
		else
			q <= d;
	end

	assign core_running     = c_act;
	assign irq_deliver      = q.irq;
	assign llc_flush_req    = (q.st == cis_pkg::P_LLC_FLUSH);
	assign llc_way_idx      = q.way;
	assign llc_pwr_en       = q.llc_on;
	assign sa_pwr_en        = q.sa_on;
	assign pkg_save_req     = (q.st == cis_pkg::P_SAVE);
	assign pkg_restore_req  = (q.st == cis_pkg::P_RESTORE) && q.saved;
	assign dom_pwr_en       = q.dom_on;
	assign pll_pwr_en       = q.pll_on;
	assign vcc_zero_req     = q.zero_req;
	assign vr_lowpwr_req    = q.lp_req;
	assign mem_retain       = q.mem_ret;
	assign platform_off_req = q.plat_off;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_flush_all_c7: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(q.st == cis_pkg::P_LLC_FLUSH) |-> $past(all_c7))
		else $error("cache flush without all cores at seventh");
	a_llc_off_empty: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(q.llc_on) |-> $past(q.st, 2) == cis_pkg::P_LLC_FLUSH &&
		$past(llc_way_done, 2) && $past(q.way, 2) == cis_pkg::WAY_LAST)
		else $error("cache voltage removed before empty");
	a_pll_after_save: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(q.pll_on) |-> q.saved && !q.llc_on && !q.dom_on)
		else $error("PLL down before state saved");
	a_zero_volt_depth: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(q.zero_req) |-> $past(pkg_min) >= cis_pkg::LVL_C9 && !q.pll_on)
		else $error("zero volt asked too early");
	a_vr_lp_depth: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(q.lp_req) |-> q.zero_req && $past(pkg_min) >= cis_pkg::LVL_C10)
		else $error("regulator low power asked too early");
	a_steer_energy: assert property (@(posedge sys_clk) disable iff (rst)
		(irq_in && !steer_perf && |c_act) |=> |(q.irq & $past(c_act)))
		else $error("interrupt woke idle core");
	a_steer_perf: assert property (@(posedge sys_clk) disable iff (rst)
		(irq_in && steer_perf && |c_halt) |=> |(q.irq & $past(c_halt)))
		else $error("interrupt not sent to halted core");
	a_exit_order: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(pkg_restore_req) |-> q.pll_on && q.dom_on && !q.zero_req &&
		!q.llc_on)
		else $error("restore before power and PLL back");

endmodule : cis_top

// File: dv/cis_vr_model.sv
// Model of the platform regulator and rails beside the sequencer.
// Assumes requests are registered levels; acks return as pins.
`timescale 1ns/1ps
module cis_vr_model (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic vcc_zero_req,
	input  wire logic vr_lowpwr_req,
	input  wire logic platform_off_req,
	output logic      vr_zero_ack = 1'b0,
	output logic      vr_lp_ack = 1'b0,
	output logic      plat_pwr_on = 1'b1
);
	logic [2:0] dly_q = 3'h0;

	////////////////////////////////////////////////////////////////////
	// Acks follow requests after a settle time; slow mode stretches it
	// so the sequencer's ack filter is exercised with long waits too.
	// regulator obeys its requests
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			dly_q       <= 3'h0;
			vr_zero_ack <= 1'b0;
			vr_lp_ack   <= 1'b0;
		end
		else if ((vcc_zero_req != vr_zero_ack) || (vr_lowpwr_req != vr_lp_ack))
		begin
			dly_q <= dly_q + 3'h1;
			if (dly_q >= (slow ? 3'h6 : 3'h1))
			begin
				dly_q       <= 3'h0;
				vr_zero_ack <= vcc_zero_req;
				vr_lp_ack   <= vr_lowpwr_req;
			end
		end
	end

	// platform drops rails on soft off
	always @(posedge sys_clk)
	begin
		plat_pwr_on <= rst | ~platform_off_req;
	end
endmodule : cis_vr_model

// File: dv/cis_top_test.sv
// Self-checking bench of the idle-state sequencer top.
// Assumes a 10 MHz clock; engine done pulses are answered here at random.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cis_top_test;
	logic        sys_clk;
	logic        rst = 1'b1;
	logic [15:0] thread_lvl = 16'h0000;
	logic [1:0]  wake_monitor = 2'h0, wake_timer = 2'h0, core_busy = 2'h0;
	logic [1:0]  core_flush_done = 2'h0, core_save_done = 2'h0;
	logic [1:0]  core_restore_done = 2'h0, sleep_req = 2'h0;
	logic        irq_in = 1'b0, steer_perf = 1'b0, llc_way_done = 1'b0;
	logic        pkg_save_done = 1'b0, pkg_restore_done = 1'b0;
	logic        pll_lock = 1'b0, slow = 1'b0;
	logic        vr_zero_ack, vr_lp_ack, plat_pwr_on;
	logic [1:0]  core_flush_req, core_save_req, core_restore_req, core_clk_en;
	logic [1:0]  core_pwr_en, core_low_freq, core_running, irq_deliver;
	logic        llc_flush_req, llc_pwr_en, sa_pwr_en, pkg_save_req;
	logic        pkg_restore_req, dom_pwr_en, pll_pwr_en, vcc_zero_req;
	logic        vr_lowpwr_req, mem_retain, platform_off_req;
	logic [2:0]  llc_way_idx;
	logic [31:0] seed = 32'h0000_0050, r;
	int          mismatches = 0, check_count = 0, n, d;
	logic [1:0]  sf, ss;
	logic [7:0]  hl[3] = '{8'h20, 8'h32, 8'h13};
	logic [4:0]  st[6] = '{5'h08, 5'h09, 5'h13, 5'h03, 5'h18, 5'h07};

	cis_top      cis_top_i (.*);
	cis_vr_model cis_vr_model_i (.sys_clk(sys_clk), .rst(rst), .slow(slow),
		.vcc_zero_req(vcc_zero_req), .vr_lowpwr_req(vr_lowpwr_req),
		.platform_off_req(platform_off_req), .vr_zero_ack(vr_zero_ack),
		.vr_lp_ack(vr_lp_ack), .plat_pwr_on(plat_pwr_on));

	////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Expected one-hot target of an interrupt; lowest index wins ties
	function automatic logic [1:0] steer(logic [1:0] h, b, logic p);
		logic [1:0] a, c;
		a = ~h;
		c = p ? (h != 0 ? h : (a & ~b) != 0 ? a & ~b : a) : (a != 0 ? a : h);
		if (c == 2'h0)
			c = 2'h1;
		return c & -c;
	endfunction : steer

	// Settled point of each package depth
	function automatic logic deep(int k);
		return k == 5 ? !llc_pwr_en : k == 6 ? !pll_pwr_en :
			k == 7 ? vr_zero_ack : vr_lp_ack;
	endfunction : deep

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// Clear levels, wake both cores, wait for both to run again
	task automatic wk(input int lim);
		thread_lvl = 16'h0000;
		r = rnd();
		if (r[0])
			wake_timer = 2'h3;
		else
			wake_monitor = 2'h3;
		@(negedge sys_clk);
		wake_timer = 2'h0;
		wake_monitor = 2'h0;
		for (n = 0; n < lim && core_running !== 2'h3; n++) @(negedge sys_clk);
		`CHK(core_running, 2'h3)
	endtask : wk

	////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Engines answer with random stalls; lock is held once reached
	always @(negedge sys_clk)
	begin
		r = rnd();
		core_flush_done   <= core_flush_req & r[1:0];
		core_save_done    <= core_save_req & r[3:2];
		core_restore_done <= core_restore_req & r[5:4];
		llc_way_done      <= llc_flush_req & r[6];
		pkg_save_done     <= pkg_save_req & r[7];
		pkg_restore_done  <= pkg_restore_req & r[8];
		pll_lock          <= pll_pwr_en & (pll_lock | r[9]);
		slow              <= r[10];
	end

	// Power ordering invariants, watched every cycle
	always @(negedge sys_clk)
	begin
		if (!rst)
		begin
			`CHK(core_running & ~core_clk_en | core_clk_en & ~core_pwr_en, 2'h0)
			`CHK(llc_flush_req & (core_pwr_en != 2'h0), 1'b0)
			`CHK(~dom_pwr_en & llc_pwr_en | vcc_zero_req & dom_pwr_en, 1'b0)
			`CHK(~pll_pwr_en & dom_pwr_en, 1'b0)
			// Core restore only runs with voltage back and clock off; package restore with PLL on and cache off
			`CHK(core_restore_req & (~core_pwr_en | core_clk_en), 2'h0)
			`CHK(pkg_restore_req & ~(pll_pwr_en & ~llc_pwr_en), 1'b0)
			`CHK(pkg_save_req & (llc_pwr_en | ~dom_pwr_en), 1'b0)
		end
	end

	// Watchdog: far beyond the few thousand cycles the tests need
	initial
	begin
		#2000000;
		mismatches++;
		$display("BAD t=%0t timeout", $time);
		conclude();
	end

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		`CHK({core_clk_en, core_pwr_en, llc_pwr_en, sa_pwr_en, dom_pwr_en, pll_pwr_en}, 8'hFF)
		`CHK({irq_deliver, core_low_freq, llc_way_idx, core_running}, 9'h003)
		$display("test reset done");
		// Halt levels: active thread wins, enhanced halt lowers the point
		foreach (hl[i])
		begin
			thread_lvl = {8'h00, hl[i]};
			repeat (3) @(negedge sys_clk);
			`CHK({core_running[0], core_low_freq[0], core_clk_en[0]}, {i == 0, i == 1, 1'b1})
			wk(20);
		end
		$display("test halt done");
		// Core 0 to third level, core 1 to sixth level
		thread_lvl = 16'h4433;
		sf = 2'h0;
		ss = 2'h0;
		for (n = 0; n < 300 && (core_pwr_en[1] || core_clk_en[0]); n++)
		begin
			sf |= core_flush_req & core_clk_en;
			ss |= core_save_req & core_pwr_en;
			@(negedge sys_clk);
		end
		`CHK({core_clk_en, core_pwr_en, sf, ss}, 8'h1E)
		wk(300);
		$display("test core done");
		// Package depths, each with one sleep request
		for (d = 5; d <= 8; d++)
		begin
			thread_lvl = {4{d[3:0]}};
			for (n = 0; n < 600 && !deep(d); n++) @(negedge sys_clk);
			`CHK({llc_pwr_en, sa_pwr_en, dom_pwr_en, pll_pwr_en, vcc_zero_req, vr_lowpwr_req, core_pwr_en}, {4'h0, d < 6, d < 6, d > 6, d > 7} << 2)
			sleep_req = 2'(d - 5);
			repeat (8) @(negedge sys_clk);
			`CHK({mem_retain, platform_off_req, plat_pwr_on}, {d == 6, d > 6, d < 7})
			sleep_req = 2'h0;
			wk(600);
			`CHK({llc_pwr_en, sa_pwr_en, dom_pwr_en, pll_pwr_en, core_clk_en, core_pwr_en, vcc_zero_req, vr_lowpwr_req, mem_retain, platform_off_req}, 12'hFF0)
		end
		$display("test package done");
		// Interrupt steering under both policies
		foreach (st[i])
		begin
			thread_lvl = {{2{3'h0, st[i][4]}}, {2{3'h0, st[i][3]}}};
			core_busy = st[i][2:1];
			steer_perf = st[i][0];
			repeat (3) @(negedge sys_clk);
			irq_in = 1'b1;
			@(negedge sys_clk);
			irq_in = 1'b0;
			`CHK(irq_deliver, steer(st[i][4:3], st[i][2:1], st[i][0]))
			wk(20);
		end
		$display("test steering done");
		conclude();
	end
endmodule : cis_top_test
